// [logic/igf_pkg.sv]
package igf_pkg;

    localparam int unsigned IGF_PINS = 16;
    localparam int unsigned IGF_CELLS_DEF = 256;
    localparam int unsigned IGF_CELLS_A = 128;
    localparam int unsigned IGF_CELLS_B = 256;
    localparam int unsigned IGF_CELLS_C = 384;
    localparam int unsigned IGF_CELLS_D = 512;

    localparam logic [IGF_PINS-1:0] IGF_EN_RST = 16'h0000;
    localparam logic [IGF_PINS-1:0] IGF_LVL_RST = 16'h0000;
    localparam logic IGF_RAIL_EN_RST = 1'h0;
    localparam logic IGF_BIT_RST = 1'h0;

    typedef logic [IGF_PINS-1:0] igf_vec_t;

    // Forwarded pass-through pins toward other chips
    typedef struct packed {
        igf_vec_t lvl;
        igf_vec_t oe_n;
        igf_vec_t keep;
    } igf_fwd_s;

    // Per-pin participation enables and one shared rail enable
    typedef struct packed {
        igf_vec_t part_en;
        logic rail_en;
    } igf_cfg_s;

    function automatic logic igf_has_gate(input int unsigned cells);
        return (cells == IGF_CELLS_A) || (cells == IGF_CELLS_B) ||
               (cells == IGF_CELLS_C) || (cells == IGF_CELLS_D);
    endfunction

endpackage

// [logic/igf_gate_cell.sv]
`timescale 1ns/100ps
module igf_gate_cell
    import igf_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // Pad and control
    input wire logic pin_i,
    input wire logic part_en_i,
    input wire logic rail_i,
    input wire logic fwd_oe_n_i,
    // Core and forward side
    output logic core_o,
    output logic fwd_lvl_o,
    output logic fwd_oe_n_o,
    output logic keep_o
);

    logic hold_r;
    logic hold_nxt;
    logic keep_r;
    logic keep_nxt;
    logic gated;

    // Block only when this pin takes part and the rail is up
    assign gated = rail_i & part_en_i;

    // Freeze path is a mux, no extra stage on the gated path
    assign core_o = gated ? hold_r : pin_i;
    assign fwd_lvl_o = core_o;
    assign fwd_oe_n_o = fwd_oe_n_i;
    assign keep_o = fwd_oe_n_i ? keep_r : fwd_lvl_o;

    always_comb begin
        hold_nxt = gated ? hold_r : pin_i;
        keep_nxt = fwd_oe_n_i ? keep_r : fwd_lvl_o;
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hold_r <= IGF_BIT_RST;
            keep_r <= IGF_BIT_RST;
        end else begin
            hold_r <= hold_nxt;
            keep_r <= keep_nxt;
        end
    end

endmodule

// [logic/igf_input_gate.sv]
`timescale 1ns/100ps
module igf_input_gate
    import igf_pkg::*;
#(
    parameter int unsigned CELLS = IGF_CELLS_DEF
)
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // Input pads
    input wire igf_vec_t pin_i,
    // Configuration
    input wire igf_cfg_s cfg_i,
    // Designated logic cell output
    input wire logic rail_cell_i,
    // Other tri-state conditions on forwarded pins
    input wire igf_vec_t fwd_oe_n_i,
    // Core side
    output igf_vec_t core_o,
    output logic rail_o,
    output igf_vec_t gated_o,
    // Forwarded pins
    output igf_fwd_s fwd_o
);

    localparam logic GATE_AVAIL = igf_has_gate(CELLS);

    igf_vec_t part_en_r;
    igf_vec_t part_en_nxt;
    logic rail_en_r;
    logic rail_en_nxt;
    logic rail;

    // Configuration is held from reset so pins pass until enabled
    always_comb begin
        part_en_nxt = cfg_i.part_en;
        rail_en_nxt = cfg_i.rail_en & GATE_AVAIL;
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            part_en_r <= IGF_EN_RST;
            rail_en_r <= IGF_RAIL_EN_RST;
        end else begin
            part_en_r <= part_en_nxt;
            rail_en_r <= rail_en_nxt;
        end
    end

    // Rail follows the designated cell with no register in between
    assign rail = GATE_AVAIL & rail_en_r & rail_cell_i;
    assign rail_o = rail;
    assign gated_o = rail ? part_en_r : IGF_EN_RST;

    // One gate cell per pad
    for (genvar i = 0; i < IGF_PINS; i++) begin : g_pin
        igf_gate_cell u_cell (
            .sys_clk_i (sys_clk_i),
            .arst_n_i (arst_n_i),
            .pin_i (pin_i[i]),
            .part_en_i (part_en_r[i]),
            .rail_i (rail),
            .fwd_oe_n_i (fwd_oe_n_i[i]),
            .core_o (core_o[i]),
            .fwd_lvl_o (fwd_o.lvl[i]),
            .fwd_oe_n_o (fwd_o.oe_n[i]),
            .keep_o (fwd_o.keep[i])
        );
    end

    // Checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    AST_RAIL_OFF: assert property (
        !rail_en_r |-> !rail_o
    ) else $error("rail active while not enabled");

    AST_RAIL_FOLLOW: assert property (
        rail_en_r ##1 rail_en_r |-> rail_o == rail_cell_i
    ) else $error("rail does not follow designated cell");

    AST_NO_GATE_VARIANT: assert property (
        !GATE_AVAIL |-> !rail_o && (core_o == pin_i)
    ) else $error("gating present on small variant");

    AST_PASS_OPEN: assert property (
        !rail_o |-> core_o == pin_i
    ) else $error("live pin not passed with rail released");

    AST_NONPART_PASS: assert property (
        (core_o & ~part_en_r) == (pin_i & ~part_en_r)
    ) else $error("non participating pin altered");

    AST_SUBSET_GATED: assert property (
        rail_o |-> gated_o == part_en_r
    ) else $error("gated set differs from enables");

    AST_CAPTURE_AT_ONCE: assert property (
        !rail_o ##1 (rail_o && $stable(part_en_r)) |->
            (core_o & part_en_r) == ($past(pin_i) & part_en_r)
    ) else $error("freeze level not prior pin level");

    AST_FREEZE_HOLD: assert property (
        rail_o ##1 (rail_o && $stable(part_en_r)) |->
            (core_o & part_en_r) == ($past(core_o) & part_en_r)
    ) else $error("frozen level moved while gated");

    AST_BLOCKED: assert property (
        rail_o && part_en_r[0] ##1 rail_o && part_en_r[0] |->
            $stable(core_o[0])
    ) else $error("gated pin reached the core");

    AST_FWD_FROZEN: assert property (
        fwd_o.lvl == core_o
    ) else $error("forwarded level not the gated value");

    AST_KEEP_HOLD: assert property (
        !fwd_o.oe_n[0] ##1 fwd_o.oe_n[0] [*2] |->
            fwd_o.keep[0] == $past(fwd_o.lvl[0], 2)
    ) else $error("keeper lost the last driven level");

    AST_KEEP_DRIVE: assert property (
        !fwd_o.oe_n[0] |-> fwd_o.keep[0] == fwd_o.lvl[0]
    ) else $error("keeper differs from driven level");

    AST_RAIL_ONLY_CELL: assert property (
        rail_o |-> rail_cell_i && rail_en_r
    ) else $error("rail raised without designated cell");

    AST_SMALL_NO_EN: assert property (
        !GATE_AVAIL |-> !rail_en_r
    ) else $error("rail enable set on small variant");

    AST_GATED_SET: assert property (
        gated_o == (part_en_r & {IGF_PINS{rail_o}})
    ) else $error("gated set not enables under rail");

    AST_NONE_GATED: assert property (
        !rail_o |-> gated_o == IGF_EN_RST
    ) else $error("pin gated with rail released");

    AST_CFG_TAKEN: assert property (
        $past(arst_n_i) |-> part_en_r == $past(cfg_i.part_en)
    ) else $error("participation enables not taken");

    AST_RAIL_EN_TAKEN: assert property (
        $past(arst_n_i) |->
            rail_en_r == ($past(cfg_i.rail_en) && GATE_AVAIL)
    ) else $error("rail enable not taken from configuration");

    // Per-pin checks
    for (genvar j = 0; j < IGF_PINS; j++) begin : g_chk
        AST_PIN_FLAG: assert property (
            gated_o[j] == (rail_o && part_en_r[j])
        ) else $error("pin gated flag wrong");

        AST_PIN_BLOCKED: assert property (
            rail_o && part_en_r[j] ##1 rail_o && part_en_r[j] |->
                $stable(core_o[j])
        ) else $error("gated pin reached the core");

        AST_PIN_AT_ONCE: assert property (
            !rail_o ##1 rail_o && part_en_r[j] && $changed(pin_i[j]) |->
                core_o[j] != pin_i[j]
        ) else $error("gated pin followed the pad at rail rise");

        AST_PIN_CAPTURE: assert property (
            !rail_o ##1 rail_o && part_en_r[j] && $stable(part_en_r[j])
                |-> core_o[j] == $past(pin_i[j])
        ) else $error("pin not frozen at its prior level");

        AST_PIN_RELEASE: assert property (
            rail_o ##1 !rail_o |-> core_o[j] == pin_i[j]
        ) else $error("released pin not live again");

        AST_PIN_IDLE: assert property (
            !part_en_r[j] |-> core_o[j] == pin_i[j]
        ) else $error("non participating pin altered");

        AST_PIN_FWD: assert property (
            fwd_o.lvl[j] == core_o[j]
        ) else $error("forwarded pin not the gated value");

        AST_PIN_OE: assert property (
            fwd_o.oe_n[j] == fwd_oe_n_i[j]
        ) else $error("forwarded enable not passed");

        AST_PIN_KEEP_HOLD: assert property (
            !fwd_o.oe_n[j] ##1 fwd_o.oe_n[j] |->
                fwd_o.keep[j] == $past(fwd_o.lvl[j])
        ) else $error("keeper lost the last driven pin level");

        AST_PIN_KEEP_STAY: assert property (
            fwd_o.oe_n[j] ##1 fwd_o.oe_n[j] |-> $stable(fwd_o.keep[j])
        ) else $error("keeper level moved while released");

        AST_PIN_KEEP_DRIVE: assert property (
            !fwd_o.oe_n[j] |-> fwd_o.keep[j] == fwd_o.lvl[j]
        ) else $error("keeper differs from driven pin");
    end

    COV_RAIL_RISE: cover property (
        !rail_o ##1 rail_o && (part_en_r != IGF_EN_RST)
    );

    COV_LONG_FREEZE: cover property (
        (rail_o && part_en_r[0]) [*4] ##1 !rail_o
    );

    COV_PIN_MOVES_GATED: cover property (
        rail_o && part_en_r[0] && (pin_i[0] != core_o[0])
    );

    COV_KEEPER: cover property (
        !fwd_o.oe_n[0] ##1 fwd_o.oe_n[0] [*3]
    );

    COV_RELEASE: cover property (
        rail_o && part_en_r[0] ##1 !rail_o && $changed(core_o[0])
    );

endmodule

// [sim/igf_bus_model.sv]
`timescale 1ns/100ps
module igf_bus_model
    import igf_pkg::*;
(
    // Clock
    input wire logic sys_clk_i,
    // Bench request
    input wire logic wr_i,
    input wire igf_vec_t dat_i,
    // Pads
    output igf_vec_t pin_o
);
    // Released bus keeps switching: inverse of last value
    always_ff @(posedge sys_clk_i) begin
        pin_o <= wr_i ? dat_i : ~pin_o;
    end
endmodule

// [sim/igf_input_gate_tb.sv]
`timescale 1ns/100ps
module igf_input_gate_tb;
    import igf_pkg::*;
    logic sys_clk_i;
    logic arst_n_i;
    logic wr;
    logic rail_cell;
    logic rail;
    logic rail_s;
    igf_vec_t dat, pin, core, gated, oe_n, core_s;
    igf_cfg_s cfg;
    igf_fwd_s fwd;
    int fail_count = 0;
    int total_checks = 0;
    igf_bus_model i_bus(.sys_clk_i(sys_clk_i), .wr_i(wr), .dat_i(dat),
        .pin_o(pin));
    igf_input_gate #(.CELLS(IGF_CELLS_D)) i_dut(.sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i), .pin_i(pin), .cfg_i(cfg),
        .rail_cell_i(rail_cell), .fwd_oe_n_i(oe_n), .core_o(core),
        .rail_o(rail), .gated_o(gated), .fwd_o(fwd));
    igf_input_gate #(.CELLS(64)) i_small(.sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i), .pin_i(pin), .cfg_i(cfg),
        .rail_cell_i(rail_cell), .fwd_oe_n_i(oe_n), .core_o(core_s),
        .rail_o(rail_s), .gated_o(), .fwd_o());
    task automatic chk(input igf_vec_t exp, input igf_vec_t got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Freeze the masked pins while the bus keeps switching
    task automatic t_freeze(input igf_vec_t mask);
        igf_vec_t held;
        @(posedge sys_clk_i);
        cfg <= {mask, 1'b1};
        wr <= 1'b1;
        dat <= 16'hA5C3 ^ mask;
        held = 16'hA5C3 ^ mask;
        @(posedge sys_clk_i);
        wr <= 1'b0;
        @(posedge sys_clk_i);
        rail_cell <= 1'b1;
        #5;
        chk(16'h0001, {15'h0000, rail});
        chk(mask, gated);
        chk((held & mask) | (pin & ~mask), core);
        repeat (3) begin
            @(posedge sys_clk_i);
            #5;
            chk((held & mask) | (pin & ~mask), core);
            chk((held & mask) | (pin & ~mask), fwd.lvl);
            chk(pin, core_s);
            chk(16'h0000, {15'h0000, rail_s});
        end
        @(posedge sys_clk_i);
        rail_cell <= 1'b0;
        #5;
        chk(pin, core);
        chk(16'h0000, gated);
    endtask
    // Rail cell high with rail driving disabled
    task automatic t_no_rail();
        @(posedge sys_clk_i);
        cfg <= {16'hFFFF, 1'b0};
        @(posedge sys_clk_i);
        rail_cell <= 1'b1;
        repeat (3) begin
            @(posedge sys_clk_i);
            #5;
            chk(16'h0000, {15'h0000, rail});
            chk(pin, core);
        end
        @(posedge sys_clk_i);
        rail_cell <= 1'b0;
    endtask
    // Forwarded pins tri-stated by another condition
    task automatic t_keep();
        igf_vec_t last;
        @(posedge sys_clk_i);
        #5;
        last = pin;
        @(posedge sys_clk_i);
        oe_n <= 16'hFFFF;
        repeat (3) begin
            @(posedge sys_clk_i);
            #5;
            chk(last, fwd.keep);
            chk(16'hFFFF, fwd.oe_n);
        end
        @(posedge sys_clk_i);
        oe_n <= 16'h0000;
        #5;
        chk(pin, fwd.keep);
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        #20000;
        fail_count++;
        end_of_test();
    end
    initial begin
        arst_n_i = 1'b0;
        wr = 1'b1;
        dat = 16'h3C5A;
        rail_cell = 1'b0;
        oe_n = 16'h0000;
        cfg = '0;
        repeat (3) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        #5;
        chk(pin, core);
        t_freeze(16'h00FF);
        t_freeze(16'hFFFF);
        t_freeze(16'h0000);
        t_no_rail();
        t_keep();
        end_of_test();
    end
endmodule
